// ---- tb_trackpad_config_registers.sv ----
/*
  Self-checking bench of the configuration bank with a host model on the link.
  Assumes the bank and host model compile first; clocks are made here.
*/
module tb_trackpad_config_registers
  import tpcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, rst, link_clk, link_rst, cycle_start, auto_prox_cycle;
  logic pad_retune_due, wake_retune_due, ready_n, watchdog_en, pad_retune_go;
  logic wake_retune_go, calibration_en, oscillator_select, moving_average_en;
  logic recursive_filter_en, fixed_damping, wake_channel_count_filter, sensing_method;
  logic acc_valid, win_request, link_end, acc_busy, acc_hold, acc_done, acc_refused;
  logic [2:0]  auto_mode, host_mode, power_mode;
  logic [3:0]  oscillator_trim;
  logic [5:0]  deep_sleep_prox_cycles, light_sleep_prox_cycles, gesture_select;
  logic [7:0]  calibration_channel, wake_rx_select;
  logic [12:0] wake_tx_select;
  logic [15:0] pos_col, pos_row, pos_x, pos_y, count_limit, acc_rdata, rd;
  tpcfg_events_s events;
  tpcfg_access_s acc_req;
  logic [15:0] exp_q [8];
  logic [15:0] msk [8];
  logic        ok, rf;
  int          num_errors, compares;
  int          ebit [5] = '{14, 13, 11, 10, 9};
  logic [9:0]  evec [5] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h001};

  tpcfg_bank u_dut (.clock, .rst, .events, .cycle_start, .auto_prox_cycle, .pad_retune_due,
    .wake_retune_due, .auto_mode, .host_mode, .pos_col, .pos_row, .ready_n, .power_mode,
    .watchdog_en, .pad_retune_go, .wake_retune_go, .calibration_en, .calibration_channel,
    .oscillator_select, .oscillator_trim, .count_limit, .deep_sleep_prox_cycles,
    .light_sleep_prox_cycles, .moving_average_en, .recursive_filter_en, .fixed_damping,
    .pos_x, .pos_y, .wake_channel_count_filter, .sensing_method, .wake_rx_select,
    .wake_tx_select, .gesture_select, .link_clk, .link_rst, .acc_valid, .acc_req,
    .win_request, .link_end, .acc_busy, .acc_hold, .acc_done, .acc_refused, .acc_rdata);

  tpcfg_host_model u_host (.link_clk, .link_rst, .acc_req, .acc_valid, .win_request,
    .link_end, .acc_busy, .acc_done, .acc_refused, .acc_rdata);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Odd offset keeps the link edges clear of the core edges
  initial
  begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  function automatic logic [15:0] lim(input logic [1:0] c);
    return (c == 2'd3) ? 16'd16384 : 16'((1024 << c) - 1);
  endfunction : lim

  function automatic logic [5:0] prox(input logic [2:0] v);
    return v[2] ? 6'd0 : 6'(4 << v[1:0]);
  endfunction : prox

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string m);
    compares++;
    if (got !== want)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d, rd, ok, rf);
    exp_q[a] = d & msk[a];
    chk(16'(ok), 16'h0001, "write not done");
    chk(rd, exp_q[a], "write echo");
    cyc(4);
  endtask : wr

  task automatic rdchk(input logic [2:0] a);
    u_host.access(1'b0, a, 16'h0000, rd, ok, rf);
    chk(16'(ok), 16'h0001, "read not done");
    chk(rd, exp_q[a], "read back");
  endtask : rdchk

  task automatic win(input int which);
    u_host.pulse(which);
    cyc(10);
  endtask : win

  task automatic chk_fields();
    chk(16'(watchdog_en), 16'(exp_q[0][5]), "watchdog");
    chk(16'(calibration_channel), 16'(exp_q[1][15:8]), "cal channel");
    chk(16'(calibration_en), 16'(exp_q[1][15:8] != 8'hFF), "cal enable");
    chk(16'({oscillator_select, oscillator_trim}), 16'(exp_q[1][4:0]), "osc");
    chk(count_limit, lim(exp_q[3][9:8]), "count limit");
    chk(16'(deep_sleep_prox_cycles), 16'(prox(exp_q[3][7:5])), "deep prox");
    chk(16'(light_sleep_prox_cycles), 16'(prox(exp_q[3][4:2])), "light prox");
    chk(16'({moving_average_en, fixed_damping, recursive_filter_en}), 16'(exp_q[4][5:3]),
        "filters");
    chk(16'({wake_channel_count_filter, sensing_method, wake_rx_select}),
        16'(exp_q[5][9:0]), "wake setup");
    chk(16'(wake_tx_select), 16'(exp_q[6][12:0]), "wake tx");
    chk(16'(gesture_select), 16'(exp_q[7][5:0]), "gestures");
  endtask : chk_fields

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Whole run needs well under half of this span
  initial
  begin
    #2000000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    num_errors = 0;
    compares = 0;
    rst = 1'b1;
    link_rst = 1'b1;
    events = '0;
    cycle_start = 1'b0;
    auto_prox_cycle = 1'b0;
    pad_retune_due = 1'b0;
    wake_retune_due = 1'b0;
    auto_mode = 3'h0;
    host_mode = 3'h0;
    pos_col = 16'h0000;
    pos_row = 16'h0000;
    msk = '{MASK_EVT_CTRL, MASK_CAL_OSC, MASK_CONV_FRQ, MASK_SENS_HW, MASK_PAD_GEOM,
            MASK_WAKE_SET, MASK_WAKE_TX, MASK_GESTURE};
    for (int i = 0; i < 8; i++) exp_q[i] = (i == 1) ? RST_CAL_OSC : RST_OTHER;
    void'($urandom(63));
    cyc(20);
    rst = 1'b0;
    link_rst = 1'b0;
    win(0);
    for (int i = 0; i < 8; i++) rdchk(i[2:0]);
    chk_fields();
    $display("test reset values done");
    for (int i = 0; i < 8; i++) wr(i[2:0], 16'($urandom()));
    for (int i = 0; i < 8; i++) rdchk(i[2:0]);
    chk_fields();
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h3, {6'h00, i[1:0], i[2:0], i[2:0], 2'b00});
      chk_fields();
    end
    $display("test field decode done");
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h4, {13'h0, i[2:0]});
      pos_col = 16'($urandom());
      pos_row = 16'($urandom());
      cyc(2);
      chk(pos_x, (i[2] ? pos_row : pos_col) ^ {16{i[0]}}, "pos x");
      chk(pos_y, (i[2] ? pos_col : pos_row) ^ {16{i[1]}}, "pos y");
    end
    $display("test orientation done");
    for (int i = 0; i < 10; i++)
    begin
      wr(3'h0, (i >= 5) ? 16'h0080 : 16'h0000);
      host_mode = 3'(i % 5);
      auto_mode = 3'(4 - i % 5);
      cyc(2);
      chk(16'(power_mode), 16'((i >= 5) ? host_mode : auto_mode), "power mode");
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h0, {10'h000, i[1], 1'b0, i[1:0], 2'b00});
      pad_retune_due = 1'b1;
      wake_retune_due = 1'b1;
      cyc(1);
      pad_retune_due = 1'b0;
      wake_retune_due = 1'b0;
      chk(16'(pad_retune_go), 16'(i[0]), "pad retune");
      chk(16'(wake_retune_go), 16'(i[1]), "wake retune");
      chk(16'(watchdog_en), 16'(i[1]), "watchdog");
    end
    $display("test mode and retune done");
    wr(3'h0, 16'h0000);
    win(1);
    chk(16'(ready_n), 16'h0001, "window closed");
    for (int i = 0; i < 2; i++)
    begin
      auto_prox_cycle = (i == 0);
      cycle_start = 1'b1;
      cyc(1);
      cycle_start = 1'b0;
      cyc(2);
      chk(16'(ready_n), 16'(i == 0), "cycle window");
    end
    wr(3'h7, 16'h003F);
    for (int i = 0; i < 10; i++)
    begin
      win(0);
      wr(3'h0, 16'h0100 | (i[0] ? 16'(1) << ebit[i / 2] : 16'h0000));
      win(1);
      events = tpcfg_events_s'(evec[i / 2]);
      cyc(1);
      events = '0;
      cyc(2);
      chk(16'(ready_n), 16'(!i[0]), "event window");
    end
    $display("test windows done");
    win(0);
    wr(3'h0, 16'h0010);
    win(1);
    u_host.access(1'b0, 3'h0, 16'h0000, rd, ok, rf);
    chk(16'(rf), 16'h0001, "refused");
    win(0);
    wr(3'h0, 16'h0000);
    win(1);
    fork
      u_host.access(1'b0, 3'h7, 16'h0000, rd, ok, rf);
      begin
        cyc(30);
        chk(16'(acc_hold), 16'h0001, "held");
        chk(16'(acc_busy), 16'h0001, "busy while held");
        cycle_start = 1'b1;
        cyc(1);
        cycle_start = 1'b0;
      end
    join
    chk(rd, exp_q[7], "held read");
    $display("test access policy done");
    end_sim();
  end
endmodule : tb_trackpad_config_registers

// ---- tpcfg_bank.sv ----
/*
  Trackpad configuration bank with comms window control and link access port.
  Assumes sensing engine strobes on the core clock and a host port on link_clk.
*/
// What this block does
// [RULE1] Touch toggles raise events when bit 14 set
// [RULE2] Wake channel toggles raise events when bit 13
// [RULE3] Retune completion raises event when bit 11
// [RULE4] Pad activity raises event when bit 10
// [RULE5] Enabled gestures raise event when bit 9
// [RULE6] Bit 8 picks per-cycle or event-driven windows
// [RULE7] Bit 7 hands power mode choice to host
// [RULE8] Watchdog runs only while bit 5 set
// [RULE9] Bit 4: stretch until window, else request
// [RULE10] Wake channel auto retune only with bit 3
// [RULE11] Pad auto retune only with bit 2
// [RULE12] Calibration channel field, 255 means disconnected
// [RULE13] Oscillator select bit 4, trim in bits 3-0
// [RULE14] Count limit field picks 1023 to 16384
// [RULE15] Deep sleep auto-prox cycles, 1xx disables
// [RULE16] Light sleep auto-prox cycles, 1xx disables
// [RULE17] Axis swap exchanges column and row electrodes
// [RULE18] Flip bits invert reported X and Y
// [RULE19] Moving average, recursive filter and damping choice
// [RULE20] Wake channel filter, method and receive electrodes
// [RULE21] Transmit electrodes join wake channel per bit
// [RULE22] Six gesture enables, one bit each
// [RULE23] Host picks power mode with three-bit code
// [RULE24] Unused bits written zero and ignored
module tpcfg_bank
  import tpcfg_pkg::*;
(
  // Core clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Sensing engine
  input  wire tpcfg_events_s       events,
  input  wire logic                cycle_start,
  input  wire logic                auto_prox_cycle,
  input  wire logic                pad_retune_due,
  input  wire logic                wake_retune_due,
  input  wire logic [2:0]          auto_mode,
  input  wire logic [2:0]          host_mode,
  input  wire logic [15:0]         pos_col,
  input  wire logic [15:0]         pos_row,
  // Engine controls
  output logic                     ready_n,
  output logic [2:0]               power_mode,
  output logic                     watchdog_en,
  output logic                     pad_retune_go,
  output logic                     wake_retune_go,
  output logic                     calibration_en,
  output logic [7:0]               calibration_channel,
  output logic                     oscillator_select,
  output logic [3:0]               oscillator_trim,
  output logic [15:0]              count_limit,
  output logic [5:0]               deep_sleep_prox_cycles,
  output logic [5:0]               light_sleep_prox_cycles,
  output logic                     moving_average_en,
  output logic                     recursive_filter_en,
  output logic                     fixed_damping,
  output logic [15:0]              pos_x,
  output logic [15:0]              pos_y,
  output logic                     wake_channel_count_filter,
  output logic                     sensing_method,
  output logic [7:0]               wake_rx_select,
  output logic [12:0]              wake_tx_select,
  output logic [5:0]               gesture_select,
  // Link side
  input  wire logic                link_clk,
  input  wire logic                link_rst,
  input  wire logic                acc_valid,
  input  wire tpcfg_access_s       acc_req,
  input  wire logic                win_request,
  input  wire logic                link_end,
  output logic                     acc_busy,
  output logic                     acc_hold,
  output logic                     acc_done,
  output logic                     acc_refused,
  output logic [15:0]              acc_rdata
);

  function automatic logic [15:0] reg_mask(input logic [2:0] idx);
    case (idx)
      IDX_EVT_CTRL: reg_mask = MASK_EVT_CTRL;
      IDX_CAL_OSC:  reg_mask = MASK_CAL_OSC;
      IDX_CONV_FRQ: reg_mask = MASK_CONV_FRQ;
      IDX_SENS_HW:  reg_mask = MASK_SENS_HW;
      IDX_PAD_GEOM: reg_mask = MASK_PAD_GEOM;
      IDX_WAKE_SET: reg_mask = MASK_WAKE_SET;
      IDX_WAKE_TX:  reg_mask = MASK_WAKE_TX;
      default:      reg_mask = MASK_GESTURE;
    endcase
  endfunction : reg_mask

  function automatic logic [5:0] prox_cycles(input logic [2:0] code);
    case (code)
      3'b000:  prox_cycles = PROX_CYC_0;
      3'b001:  prox_cycles = PROX_CYC_1;
      3'b010:  prox_cycles = PROX_CYC_2;
      3'b011:  prox_cycles = PROX_CYC_3;
      default: prox_cycles = PROX_OFF;
    endcase
  endfunction : prox_cycles

  function automatic logic [15:0] count_lim(input logic [1:0] code);
    case (code)
      2'b00:   count_lim = COUNT_LIM_0;
      2'b01:   count_lim = COUNT_LIM_1;
      2'b10:   count_lim = COUNT_LIM_2;
      default: count_lim = COUNT_LIM_3;
    endcase
  endfunction : count_lim

  // Link domain: the request is held stable while the toggle crosses
  logic          req_tgl_q;
  logic          end_tgl_q;
  logic          wreq_tgl_q;
  logic          pend_q;
  logic          busy_q;
  tpcfg_access_s lreq_q;
  logic [2:0]    ack_s_q;
  logic [1:0]    win_s_q;
  logic [1:0]    reqen_s_q;
  logic          done_q;
  logic          refused_q;
  logic [15:0]   lrdata_q;

  // Core domain
  logic [15:0]   cfg_q [N_REGS];
  logic [2:0]    req_s_q;
  logic [2:0]    end_s_q;
  logic [2:0]    wreq_s_q;
  logic          ack_tgl_q;
  logic [15:0]   rdata_q;
  logic          win_q;
  logic [2:0]    mode_q;
  logic          pad_go_q;
  logic          wake_go_q;
  logic [15:0]   x_q;
  logic [15:0]   y_q;

  wire logic        ack_edge   = ack_s_q[2] ^ ack_s_q[1];
  wire logic        launch     = pend_q & ~busy_q & win_s_q[1];
  wire logic        drop       = pend_q & ~busy_q & ~win_s_q[1] & reqen_s_q[1];

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_tgl_q  <= 1'b0;
      end_tgl_q  <= 1'b0;
      wreq_tgl_q <= 1'b0;
      pend_q     <= 1'b0;
      busy_q     <= 1'b0;
      lreq_q     <= '0;
      ack_s_q    <= '0;
      win_s_q    <= '0;
      reqen_s_q  <= '0;
      done_q     <= 1'b0;
      refused_q  <= 1'b0;
      lrdata_q   <= '0;
    end else begin
      ack_s_q   <= {ack_s_q[1:0], ack_tgl_q};
      win_s_q   <= {win_s_q[0], win_q};
      reqen_s_q <= {reqen_s_q[0], cfg_q[IDX_EVT_CTRL][B_REQUEST_EN]};
      done_q    <= ack_edge;
      refused_q <= drop; // RULE9
      if (acc_valid && !pend_q && !busy_q) begin
        pend_q <= 1'b1;
        lreq_q <= acc_req;
      end else if (launch || drop) begin
        pend_q <= 1'b0; // RULE9
      end
      if (launch) begin
        busy_q    <= 1'b1;
        req_tgl_q <= ~req_tgl_q;
      end else if (ack_edge) begin
        busy_q   <= 1'b0;
        lrdata_q <= rdata_q;
      end
      if (link_end) begin
        end_tgl_q <= ~end_tgl_q;
      end
      if (win_request) begin
        wreq_tgl_q <= ~wreq_tgl_q;
      end
    end
  end

  // Stretching is shown while a request waits for a window
  assign acc_hold    = pend_q & ~win_s_q[1] & ~reqen_s_q[1]; // RULE9
  assign acc_busy    = pend_q | busy_q;
  assign acc_done    = done_q;
  assign acc_refused = refused_q;
  assign acc_rdata   = lrdata_q;

  // Core side decode
  wire logic [15:0] ctl       = cfg_q[IDX_EVT_CTRL];
  wire logic        req_edge  = req_s_q[2] ^ req_s_q[1];
  wire logic        end_edge  = end_s_q[2] ^ end_s_q[1];
  wire logic        wreq_edge = wreq_s_q[2] ^ wreq_s_q[1];
  wire logic        do_write  = req_edge & lreq_q.write;
  wire logic [15:0] wr_val    = lreq_q.wdata & reg_mask(lreq_q.addr); // RULE24
  wire logic        touch_hit = ctl[B_TOUCH_EVT] & events.touch_toggle; // RULE1
  wire logic        wake_hit  = ctl[B_WAKE_EVT] & events.wake_toggle; // RULE2
  wire logic        tune_hit  = ctl[B_RETUNE_EVT] & events.retune_done; // RULE3
  wire logic        pad_hit   = ctl[B_PAD_EVT] & events.pad_activity; // RULE4
  wire logic        gest_hit  = ctl[B_GEST_EVT] & |(events.gesture & cfg_q[IDX_GESTURE][5:0]); // RULE5
  wire logic        event_hit = touch_hit | wake_hit | tune_hit | pad_hit | gest_hit;
  wire logic        cyc_open  = cycle_start & ~auto_prox_cycle;
  // RULE6
  wire logic        win_open  = (ctl[B_EVENT_MODE] ? event_hit : cyc_open) | wreq_edge;
  wire logic [15:0] pad_cfg   = cfg_q[IDX_PAD_GEOM];
  wire logic [15:0] col_sel   = pad_cfg[B_SWAP] ? pos_row : pos_col; // RULE17
  wire logic [15:0] row_sel   = pad_cfg[B_SWAP] ? pos_col : pos_row; // RULE17

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q[IDX_EVT_CTRL] <= RST_OTHER;
      cfg_q[IDX_CAL_OSC]  <= RST_CAL_OSC;
      cfg_q[IDX_CONV_FRQ] <= RST_OTHER;
      cfg_q[IDX_SENS_HW]  <= RST_OTHER;
      cfg_q[IDX_PAD_GEOM] <= RST_OTHER;
      cfg_q[IDX_WAKE_SET] <= RST_OTHER;
      cfg_q[IDX_WAKE_TX]  <= RST_OTHER;
      cfg_q[IDX_GESTURE]  <= RST_OTHER;
      req_s_q   <= '0;
      end_s_q   <= '0;
      wreq_s_q  <= '0;
      ack_tgl_q <= 1'b0;
      rdata_q   <= '0;
      win_q     <= 1'b0;
    end else begin
      req_s_q  <= {req_s_q[1:0], req_tgl_q};
      end_s_q  <= {end_s_q[1:0], end_tgl_q};
      wreq_s_q <= {wreq_s_q[1:0], wreq_tgl_q};
      if (do_write) begin
        cfg_q[lreq_q.addr] <= wr_val;
      end
      if (req_edge) begin
        rdata_q   <= do_write ? wr_val : cfg_q[lreq_q.addr];
        ack_tgl_q <= ~ack_tgl_q;
      end
      // Opening wins over the host closing in the same cycle
      if (win_open) begin
        win_q <= 1'b1; // RULE6
      end else if (end_edge) begin
        win_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q    <= '0;
      pad_go_q  <= 1'b0;
      wake_go_q <= 1'b0;
      x_q       <= '0;
      y_q       <= '0;
    end else begin
      // Host code is passed unchecked; the engine rejects codes above 100
      mode_q    <= ctl[B_MANUAL] ? host_mode : auto_mode; // RULE7 RULE23
      pad_go_q  <= pad_retune_due & ctl[B_PAD_RETUNE]; // RULE11
      wake_go_q <= wake_retune_due & ctl[B_WAKE_RETUNE]; // RULE10
      x_q       <= pad_cfg[B_FLIP_X] ? ~col_sel : col_sel; // RULE18
      y_q       <= pad_cfg[B_FLIP_Y] ? ~row_sel : row_sel; // RULE18
    end
  end

  assign ready_n        = ~win_q;
  assign power_mode     = mode_q;
  assign watchdog_en    = ctl[B_WATCHDOG]; // RULE8
  assign pad_retune_go  = pad_go_q;
  assign wake_retune_go = wake_go_q;
  assign pos_x          = x_q;
  assign pos_y          = y_q;

  assign calibration_channel = cfg_q[IDX_CAL_OSC][15:B_CAL_CH_LO]; // RULE12
  assign calibration_en      = cfg_q[IDX_CAL_OSC][15:B_CAL_CH_LO] != CAL_CH_OFF; // RULE12
  assign oscillator_select   = cfg_q[IDX_CAL_OSC][B_OSC_SEL]; // RULE13
  assign oscillator_trim     = cfg_q[IDX_CAL_OSC][3:0]; // RULE13

  assign count_limit = count_lim(cfg_q[IDX_SENS_HW][B_COUNT_LO+:2]); // RULE14
  assign deep_sleep_prox_cycles  = prox_cycles(cfg_q[IDX_SENS_HW][B_DEEP_LO+:3]); // RULE15
  assign light_sleep_prox_cycles = prox_cycles(cfg_q[IDX_SENS_HW][B_LIGHT_LO+:3]); // RULE16

  assign moving_average_en   = pad_cfg[B_MAV]; // RULE19
  assign recursive_filter_en = pad_cfg[B_IIR]; // RULE19
  assign fixed_damping       = pad_cfg[B_FIXED_DAMP]; // RULE19

  assign wake_channel_count_filter = cfg_q[IDX_WAKE_SET][B_WAKE_FILT]; // RULE20
  assign sensing_method            = cfg_q[IDX_WAKE_SET][B_WAKE_METHOD]; // RULE20
  assign wake_rx_select            = cfg_q[IDX_WAKE_SET][7:0]; // RULE20
  assign wake_tx_select            = cfg_q[IDX_WAKE_TX][12:0]; // RULE21
  assign gesture_select            = cfg_q[IDX_GESTURE][5:0]; // RULE22

  property p_touch_evt;
    @(posedge clock) disable iff (rst)
      events.touch_toggle && ctl[B_EVENT_MODE] && ctl[B_TOUCH_EVT] |=> win_q;
  endproperty
  a_touch_evt: assert property (p_touch_evt) else $error("touch event did not open window"); // RULE1

  property p_wake_evt;
    @(posedge clock) disable iff (rst)
      events.wake_toggle && ctl[B_EVENT_MODE] && ctl[B_WAKE_EVT] |=> win_q;
  endproperty
  a_wake_evt: assert property (p_wake_evt) else $error("wake toggle raised no event"); // RULE2

  property p_retune_evt;
    @(posedge clock) disable iff (rst)
      events.retune_done && ctl[B_EVENT_MODE] && ctl[B_RETUNE_EVT] |=> win_q;
  endproperty
  a_retune_evt: assert property (p_retune_evt) else $error("retune raised no event"); // RULE3

  property p_pad_evt;
    @(posedge clock) disable iff (rst)
      events.pad_activity && ctl[B_EVENT_MODE] && ctl[B_PAD_EVT] |=> win_q;
  endproperty
  a_pad_evt: assert property (p_pad_evt) else $error("pad activity raised no event"); // RULE4

  property p_gest_evt;
    @(posedge clock) disable iff (rst)
      gest_hit |-> ctl[B_GEST_EVT] && |(events.gesture & gesture_select);
  endproperty
  a_gest_evt: assert property (p_gest_evt) else $error("gesture event without enable"); // RULE5

  sequence s_quiet;
    !win_q && !event_hit && !wreq_edge && ctl[B_EVENT_MODE];
  endsequence

  property p_event_mode_quiet;
    @(posedge clock) disable iff (rst)
      s_quiet |=> !win_q;
  endproperty
  a_event_mode_quiet: assert property (p_event_mode_quiet) else $error("window opened without event"); // RULE6

  property p_cycle_window;
    @(posedge clock) disable iff (rst)
      !ctl[B_EVENT_MODE] && cycle_start && !auto_prox_cycle |=> !ready_n;
  endproperty
  a_cycle_window: assert property (p_cycle_window) else $error("cycle did not open window"); // RULE6

  property p_manual_mode;
    @(posedge clock) disable iff (rst)
      ctl[B_MANUAL] ##1 ctl[B_MANUAL] |-> power_mode == $past(host_mode);
  endproperty
  a_manual_mode: assert property (p_manual_mode) else $error("manual mode not followed"); // RULE7

  property p_watchdog;
    @(posedge clock) disable iff (rst)
      do_write && lreq_q.addr == IDX_EVT_CTRL |=> watchdog_en == $past(lreq_q.wdata[B_WATCHDOG]);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog enable not written"); // RULE8

  property p_pad_retune;
    @(posedge clock) disable iff (rst)
      pad_retune_go |-> $past(pad_retune_due) && $past(ctl[B_PAD_RETUNE]);
  endproperty
  a_pad_retune: assert property (p_pad_retune) else $error("pad retune while disabled"); // RULE11

  property p_unused_zero;
    @(posedge clock) disable iff (rst)
      do_write && lreq_q.addr == IDX_GESTURE |=> cfg_q[IDX_GESTURE][15:6] == 10'h000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits stored"); // RULE24

endmodule : tpcfg_bank

// ---- tpcfg_host_model.sv ----
/*
  Host model on the link port: word accesses and window commands.
  Assumes the bank samples link inputs on the rising edge of link_clk.
*/
module tpcfg_host_model
  import tpcfg_pkg::*;
(
  // Link clock and reset
  input  wire logic        link_clk,
  input  wire logic        link_rst,
  // Requests
  output tpcfg_access_s    acc_req,
  output logic             acc_valid,
  output logic             win_request,
  output logic             link_end,
  // Answers
  input  wire logic        acc_busy,
  input  wire logic        acc_done,
  input  wire logic        acc_refused,
  input  wire logic [15:0] acc_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    acc_req     = '0;
    acc_valid   = 1'b0;
    win_request = 1'b0;
    link_end    = 1'b0;
  end

  // One strobe cycle: 0 asks for a window, 1 ends it
  task automatic pulse(input int which);
    @(negedge link_clk);
    if (which == 0)
      win_request = 1'b1;
    else
      link_end = 1'b1;
    @(negedge link_clk);
    win_request = 1'b0;
    link_end    = 1'b0;
  endtask : pulse

  // Bounded wait, so a lost answer shows up as ok low instead of a hang
  task automatic access(input logic wr, input logic [2:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic ok, output logic refused);
    int n;
    n = 0;
    @(negedge link_clk);
    // One access outstanding: a request while busy would be ignored
    while (acc_busy !== 1'b0 && n < 3000)
    begin
      @(negedge link_clk);
      n++;
    end
    acc_req   = tpcfg_access_s'{write: wr, addr: a, wdata: d};
    acc_valid = 1'b1;
    @(negedge link_clk);
    acc_valid = 1'b0;
    // Released lines must not keep looking valid
    acc_req   = ~acc_req;
    while (acc_done !== 1'b1 && acc_refused !== 1'b1 && n < 3000)
    begin
      @(negedge link_clk);
      n++;
    end
    rd      = acc_rdata;
    ok      = acc_done;
    refused = acc_refused;
  endtask : access
endmodule : tpcfg_host_model

// ---- tpcfg_pkg.sv ----
/*
  Constants, masks and carriers of the trackpad configuration register bank.
  Assumes one core clock and one link clock, both with active high sync resets.
*/
package tpcfg_pkg;

  localparam int          REG_W        = 16;
  localparam int          ADDR_W       = 3;
  localparam int          N_REGS       = 8;

  // Register indices on the link
  localparam logic [2:0]  IDX_EVT_CTRL = 3'h0;
  localparam logic [2:0]  IDX_CAL_OSC  = 3'h1;
  localparam logic [2:0]  IDX_CONV_FRQ = 3'h2;
  localparam logic [2:0]  IDX_SENS_HW  = 3'h3;
  localparam logic [2:0]  IDX_PAD_GEOM = 3'h4;
  localparam logic [2:0]  IDX_WAKE_SET = 3'h5;
  localparam logic [2:0]  IDX_WAKE_TX  = 3'h6;
  localparam logic [2:0]  IDX_GESTURE  = 3'h7;

  // Writable bits; unused bits are dropped and read as zero
  localparam logic [15:0] MASK_EVT_CTRL = 16'h6FBC;
  localparam logic [15:0] MASK_CAL_OSC  = 16'hFFFF;
  localparam logic [15:0] MASK_CONV_FRQ = 16'hFFFF;
  localparam logic [15:0] MASK_SENS_HW  = 16'h7FFF;
  localparam logic [15:0] MASK_PAD_GEOM = 16'hFF3F;
  localparam logic [15:0] MASK_WAKE_SET = 16'h03FF;
  localparam logic [15:0] MASK_WAKE_TX  = 16'h1FFF;
  localparam logic [15:0] MASK_GESTURE  = 16'h003F;

  // Values after reset
  localparam logic [15:0] RST_CAL_OSC   = 16'hFF00;
  localparam logic [15:0] RST_OTHER     = 16'h0000;

  // Event and control bits
  localparam int B_TOUCH_EVT   = 14;
  localparam int B_WAKE_EVT    = 13;
  localparam int B_RETUNE_EVT  = 11;
  localparam int B_PAD_EVT     = 10;
  localparam int B_GEST_EVT    = 9;
  localparam int B_EVENT_MODE  = 8;
  localparam int B_MANUAL      = 7;
  localparam int B_WATCHDOG    = 5;
  localparam int B_REQUEST_EN  = 4;
  localparam int B_WAKE_RETUNE = 3;
  localparam int B_PAD_RETUNE  = 2;

  // Field positions
  localparam int          B_CAL_CH_LO   = 8;
  localparam int          B_OSC_SEL     = 4;
  localparam int          B_COUNT_LO    = 8;
  localparam int          B_DEEP_LO     = 5;
  localparam int          B_LIGHT_LO    = 2;
  localparam int          B_MAV         = 5;
  localparam int          B_FIXED_DAMP  = 4;
  localparam int          B_IIR         = 3;
  localparam int          B_SWAP        = 2;
  localparam int          B_FLIP_Y      = 1;
  localparam int          B_FLIP_X      = 0;
  localparam int          B_WAKE_FILT   = 9;
  localparam int          B_WAKE_METHOD = 8;
  localparam logic [7:0]  CAL_CH_OFF    = 8'hFF;

  // Conversion count limits and auto-prox cycle counts
  localparam logic [15:0] COUNT_LIM_0 = 16'd1023;
  localparam logic [15:0] COUNT_LIM_1 = 16'd2047;
  localparam logic [15:0] COUNT_LIM_2 = 16'd4095;
  localparam logic [15:0] COUNT_LIM_3 = 16'd16384;
  localparam logic [5:0]  PROX_CYC_0  = 6'd4;
  localparam logic [5:0]  PROX_CYC_1  = 6'd8;
  localparam logic [5:0]  PROX_CYC_2  = 6'd16;
  localparam logic [5:0]  PROX_CYC_3  = 6'd32;
  localparam logic [5:0]  PROX_OFF    = 6'd0;

  typedef struct packed {
    logic       touch_toggle;
    logic       wake_toggle;
    logic       retune_done;
    logic       pad_activity;
    logic [5:0] gesture;
  } tpcfg_events_s;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } tpcfg_access_s;

endpackage : tpcfg_pkg
